// >>> hw/gpio_pkg.sv
// constants for the four-port gpio block: register offsets, reset values,
// two-bit pin field encodings.
// assumes an 8-bit cpu register port with byte addresses.
package gpio_pkg;

  // register offsets
  localparam logic [7:0] OFS_P0_MODE_HIGH = 8'hE0;
  localparam logic [7:0] OFS_P0_MODE_LOW = 8'hE1;
  localparam logic [7:0] OFS_P0_PULLUP = 8'hE2;
  localparam logic [7:0] OFS_P1_MODE = 8'hE3;
  localparam logic [7:0] OFS_P2_MODE_HIGH = 8'hE4;
  localparam logic [7:0] OFS_P2_MODE_LOW = 8'hE5;
  localparam logic [7:0] OFS_P2_PULLUP = 8'hE7;
  localparam logic [7:0] OFS_P3_MODE_HIGH = 8'hE8;
  localparam logic [7:0] OFS_P3_MODE_LOW = 8'hE9;
  localparam logic [7:0] OFS_P3_IRQ_EN = 8'hEA;
  localparam logic [7:0] OFS_P3_PULLUP = 8'hEB;
  localparam logic [7:0] OFS_P3_OPEN_DRAIN = 8'hEC;
  localparam logic [7:0] OFS_P0_DATA = 8'hED;
  localparam logic [7:0] OFS_P1_DATA = 8'hEE;
  localparam logic [7:0] OFS_P2_DATA = 8'hEF;
  localparam logic [7:0] OFS_P3_DATA = 8'hF0;
  localparam logic [7:0] OFS_IRQ_PENDING = 8'hF1;

  // reset value shared by every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // port widths
  localparam int P1_PINS = 2;
  localparam logic [7:0] P1_MODE_MASK = 8'h0F;

  // port 0 pin field
  localparam logic [1:0] P0_INPUT = 2'h0;
  localparam logic [1:0] P0_PUSH_PULL = 2'h1;
  localparam logic [1:0] P0_ALT_OUT = 2'h2;
  localparam logic [1:0] P0_ANALOG = 2'h3;

  // port 1 pin field
  localparam logic [1:0] P1_INPUT = 2'h0;
  localparam logic [1:0] P1_INPUT_PULLUP = 2'h1;
  localparam logic [1:0] P1_PUSH_PULL = 2'h2;
  localparam logic [1:0] P1_ANALOG = 2'h3;

  // port 2 pin field
  localparam logic [1:0] P2_INPUT = 2'h0;
  localparam logic [1:0] P2_PUSH_PULL = 2'h1;
  localparam logic [1:0] P2_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] P2_ALT_OUT = 2'h3;

  // port 3 pin field: three input flavours pick the interrupt edge
  localparam logic [1:0] P3_IN_FALL = 2'h0;
  localparam logic [1:0] P3_IN_RISE = 2'h1;
  localparam logic [1:0] P3_IN_BOTH = 2'h2;
  localparam logic [1:0] P3_OUTPUT = 2'h3;

endpackage : gpio_pkg

// >>> hw/gpio_ports.sv
// four-port gpio block: mode, pull-up and data registers, pin drivers,
// port 3 edge interrupts with enable and pending registers.
// assumes pin inputs synchronous to clock; tri-state resolved outside.
`timescale 1ns/1ps

module gpio_ports (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // cpu register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // port 0 pins and helpers
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port0_pullup,
  output logic [7:0] port0_analog_sel,
  input wire logic [7:0] port0_alt_out,
  // port 1 pins and helpers
  input wire logic [1:0] port1_in,
  output logic [1:0] port1_out,
  output logic [1:0] port1_oe,
  output logic [1:0] port1_pullup,
  output logic [1:0] port1_analog_sel,
  // port 2 pins and helpers
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic [7:0] port2_pullup,
  input wire logic [7:0] port2_alt_out,
  // port 3 pins and helpers
  input wire logic [7:0] port3_in,
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe,
  output logic [7:0] port3_pullup,
  // interrupt request to cpu
  output logic ext_irq_n
);

  // software-visible registers
  logic [7:0] port0_mode_high_reg;
  logic [7:0] port0_mode_low_reg;
  logic [7:0] port0_pullup_enable_reg;
  logic [7:0] port1_mode_reg;
  logic [7:0] port2_mode_high_reg;
  logic [7:0] port2_mode_low_reg;
  logic [7:0] port2_pullup_enable_reg;
  logic [7:0] port3_mode_high_reg;
  logic [7:0] port3_mode_low_reg;
  logic [7:0] port3_irq_enable_reg;
  logic [7:0] port3_pullup_enable_reg;
  logic [7:0] port3_open_drain_select_reg;
  logic [7:0] port0_data_reg;
  logic [1:0] port1_data_reg;
  logic [7:0] port2_data_reg;
  logic [7:0] port3_data_reg;
  logic [7:0] ext_irq_pending_reg;
  logic [7:0] ext_irq_pending_next;

  // edge detection state
  logic [7:0] port3_prev_reg;
  logic edge_armed_reg;
  logic [7:0] edge_hit;

  // pin drive, computed then registered
  logic [7:0] p0_out_next, p0_oe_next, p0_pu_next, p0_an_next, p0_view;
  logic [1:0] p1_out_next, p1_oe_next, p1_pu_next, p1_an_next, p1_view;
  logic [7:0] p2_out_next, p2_oe_next, p2_pu_next, p2_view;
  logic [7:0] p3_out_next, p3_oe_next, p3_pu_next, p3_view;
  logic [7:0] rdata_next;

  // two-bit field of pin idx from a high/low mode register pair
  function automatic logic [1:0] pin_field(input logic [7:0] hi,
                                           input logic [7:0] lo,
                                           input logic [2:0] idx);
    logic [15:0] both;
    both = {hi, lo};
    return both[{idx, 1'b0} +: 2];
  endfunction : pin_field

  function automatic logic wr_hit(input logic [7:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction : wr_hit

  // mode and configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port0_mode_high_reg <= gpio_pkg::REG_RESET;
      port0_mode_low_reg <= gpio_pkg::REG_RESET;
      port0_pullup_enable_reg <= gpio_pkg::REG_RESET;
      port1_mode_reg <= gpio_pkg::REG_RESET;
      port2_mode_high_reg <= gpio_pkg::REG_RESET;
      port2_mode_low_reg <= gpio_pkg::REG_RESET;
      port2_pullup_enable_reg <= gpio_pkg::REG_RESET;
      port3_mode_high_reg <= gpio_pkg::REG_RESET;
      port3_mode_low_reg <= gpio_pkg::REG_RESET;
      port3_irq_enable_reg <= gpio_pkg::REG_RESET;
      port3_pullup_enable_reg <= gpio_pkg::REG_RESET;
      port3_open_drain_select_reg <= gpio_pkg::REG_RESET;
    end else begin
      if (wr_hit(gpio_pkg::OFS_P0_MODE_HIGH)) begin
        port0_mode_high_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P0_MODE_LOW)) begin
        port0_mode_low_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P0_PULLUP)) begin
        port0_pullup_enable_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P1_MODE)) begin
        port1_mode_reg <= reg_wdata & gpio_pkg::P1_MODE_MASK;
      end
      if (wr_hit(gpio_pkg::OFS_P2_MODE_HIGH)) begin
        port2_mode_high_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P2_MODE_LOW)) begin
        port2_mode_low_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P2_PULLUP)) begin
        port2_pullup_enable_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_MODE_HIGH)) begin
        port3_mode_high_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_MODE_LOW)) begin
        port3_mode_low_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_IRQ_EN)) begin
        port3_irq_enable_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_PULLUP)) begin
        port3_pullup_enable_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_OPEN_DRAIN)) begin
        port3_open_drain_select_reg <= reg_wdata;
      end
    end
  end

  // output latches: written whatever the pin mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port0_data_reg <= gpio_pkg::REG_RESET;
      port1_data_reg <= 2'h0;
      port2_data_reg <= gpio_pkg::REG_RESET;
      port3_data_reg <= gpio_pkg::REG_RESET;
    end else begin
      if (wr_hit(gpio_pkg::OFS_P0_DATA)) begin
        port0_data_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P1_DATA)) begin
        port1_data_reg <= reg_wdata[1:0];
      end
      if (wr_hit(gpio_pkg::OFS_P2_DATA)) begin
        port2_data_reg <= reg_wdata;
      end
      if (wr_hit(gpio_pkg::OFS_P3_DATA)) begin
        port3_data_reg <= reg_wdata;
      end
    end
  end

  // pin drivers; alternates come from peripherals, software enables them
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [1:0] f0;
      logic [1:0] f2;
      logic [1:0] f3;
      f0 = pin_field(port0_mode_high_reg, port0_mode_low_reg, 3'(i));
      f2 = pin_field(port2_mode_high_reg, port2_mode_low_reg, 3'(i));
      f3 = pin_field(port3_mode_high_reg, port3_mode_low_reg, 3'(i));
      // port 0: push-pull or alternate
      p0_out_next[i] = (f0 == gpio_pkg::P0_ALT_OUT) ? port0_alt_out[i]
                                                    : port0_data_reg[i];
      p0_oe_next[i] = (f0 == gpio_pkg::P0_PUSH_PULL) ||
                      (f0 == gpio_pkg::P0_ALT_OUT);
      p0_an_next[i] = (f0 == gpio_pkg::P0_ANALOG);
      p0_pu_next[i] = port0_pullup_enable_reg[i] &&
                      (f0 == gpio_pkg::P0_INPUT);
      p0_view[i] = p0_oe_next[i] ? port0_data_reg[i] : port0_in[i];
      // port 2: push-pull, open-drain or alternate
      if (f2 == gpio_pkg::P2_OPEN_DRAIN) begin
        p2_out_next[i] = 1'b0;
        p2_oe_next[i] = ~port2_data_reg[i];
      end else begin
        p2_out_next[i] = (f2 == gpio_pkg::P2_ALT_OUT) ? port2_alt_out[i]
                                                      : port2_data_reg[i];
        p2_oe_next[i] = (f2 != gpio_pkg::P2_INPUT);
      end
      p2_pu_next[i] = port2_pullup_enable_reg[i] &&
                      (f2 == gpio_pkg::P2_INPUT);
      p2_view[i] = (f2 == gpio_pkg::P2_INPUT) ? port2_in[i]
                                              : port2_data_reg[i];
      // port 3: input, push-pull or open-drain output per pin
      if (f3 != gpio_pkg::P3_OUTPUT) begin
        p3_out_next[i] = port3_data_reg[i];
        p3_oe_next[i] = 1'b0;
      end else if (port3_open_drain_select_reg[i]) begin
        p3_out_next[i] = 1'b0;
        p3_oe_next[i] = ~port3_data_reg[i];
      end else begin
        p3_out_next[i] = port3_data_reg[i];
        p3_oe_next[i] = 1'b1;
      end
      p3_pu_next[i] = port3_pullup_enable_reg[i] &&
                      (f3 != gpio_pkg::P3_OUTPUT);
      p3_view[i] = (f3 == gpio_pkg::P3_OUTPUT) ? port3_data_reg[i]
                                               : port3_in[i];
    end
    for (int j = 0; j < gpio_pkg::P1_PINS; j++) begin
      logic [1:0] f1;
      f1 = port1_mode_reg[2 * j +: 2];
      // port 1: push-pull only
      p1_out_next[j] = port1_data_reg[j];
      p1_oe_next[j] = (f1 == gpio_pkg::P1_PUSH_PULL);
      p1_pu_next[j] = (f1 == gpio_pkg::P1_INPUT_PULLUP);
      p1_an_next[j] = (f1 == gpio_pkg::P1_ANALOG);
      p1_view[j] = p1_oe_next[j] ? port1_data_reg[j] : port1_in[j];
    end
  end

  // port 3 edge detect; first cycle after reset only captures levels so a
  // pin already high at reset does not look like a rising edge
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      logic [1:0] f;
      logic rise;
      logic fall;
      f = pin_field(port3_mode_high_reg, port3_mode_low_reg, 3'(k));
      rise = port3_in[k] & ~port3_prev_reg[k];
      fall = ~port3_in[k] & port3_prev_reg[k];
      case (f)
        gpio_pkg::P3_IN_FALL: edge_hit[k] = fall;
        gpio_pkg::P3_IN_RISE: edge_hit[k] = rise;
        gpio_pkg::P3_IN_BOTH: edge_hit[k] = rise | fall;
        default: edge_hit[k] = 1'b0;
      endcase
    end
    edge_hit = edge_hit & port3_irq_enable_reg & {8{edge_armed_reg}};
  end

  // pending: writing 0 clears, 1 keeps; a new edge beats a same-cycle clear
  always_comb begin
    ext_irq_pending_next = ext_irq_pending_reg;
    if (wr_hit(gpio_pkg::OFS_IRQ_PENDING)) begin
      ext_irq_pending_next = ext_irq_pending_reg & reg_wdata;
    end
    ext_irq_pending_next = ext_irq_pending_next | edge_hit;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_irq_pending_reg <= gpio_pkg::REG_RESET;
      port3_prev_reg <= gpio_pkg::REG_RESET;
      edge_armed_reg <= 1'b0;
      ext_irq_n <= 1'b1;
    end else begin
      ext_irq_pending_reg <= ext_irq_pending_next;
      port3_prev_reg <= port3_in;
      edge_armed_reg <= 1'b1;
      ext_irq_n <= ~|ext_irq_pending_next;
    end
  end

  // pin outputs registered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
      port0_pullup <= 8'h00;
      port0_analog_sel <= 8'h00;
      port1_out <= 2'h0;
      port1_oe <= 2'h0;
      port1_pullup <= 2'h0;
      port1_analog_sel <= 2'h0;
      port2_out <= 8'h00;
      port2_oe <= 8'h00;
      port2_pullup <= 8'h00;
      port3_out <= 8'h00;
      port3_oe <= 8'h00;
      port3_pullup <= 8'h00;
    end else begin
      port0_out <= p0_out_next;
      port0_oe <= p0_oe_next;
      port0_pullup <= p0_pu_next;
      port0_analog_sel <= p0_an_next;
      port1_out <= p1_out_next;
      port1_oe <= p1_oe_next;
      port1_pullup <= p1_pu_next;
      port1_analog_sel <= p1_an_next;
      port2_out <= p2_out_next;
      port2_oe <= p2_oe_next;
      port2_pullup <= p2_pu_next;
      port3_out <= p3_out_next;
      port3_oe <= p3_oe_next;
      port3_pullup <= p3_pu_next;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    if (reg_addr == gpio_pkg::OFS_P0_MODE_HIGH) begin
      rdata_next = port0_mode_high_reg;
    end else if (reg_addr == gpio_pkg::OFS_P0_MODE_LOW) begin
      rdata_next = port0_mode_low_reg;
    end else if (reg_addr == gpio_pkg::OFS_P0_PULLUP) begin
      rdata_next = port0_pullup_enable_reg;
    end else if (reg_addr == gpio_pkg::OFS_P1_MODE) begin
      rdata_next = port1_mode_reg;
    end else if (reg_addr == gpio_pkg::OFS_P2_MODE_HIGH) begin
      rdata_next = port2_mode_high_reg;
    end else if (reg_addr == gpio_pkg::OFS_P2_MODE_LOW) begin
      rdata_next = port2_mode_low_reg;
    end else if (reg_addr == gpio_pkg::OFS_P2_PULLUP) begin
      rdata_next = port2_pullup_enable_reg;
    end else if (reg_addr == gpio_pkg::OFS_P3_MODE_HIGH) begin
      rdata_next = port3_mode_high_reg;
    end else if (reg_addr == gpio_pkg::OFS_P3_MODE_LOW) begin
      rdata_next = port3_mode_low_reg;
    end else if (reg_addr == gpio_pkg::OFS_P3_IRQ_EN) begin
      rdata_next = port3_irq_enable_reg;
    end else if (reg_addr == gpio_pkg::OFS_P3_PULLUP) begin
      rdata_next = port3_pullup_enable_reg;
    end else if (reg_addr == gpio_pkg::OFS_P3_OPEN_DRAIN) begin
      rdata_next = port3_open_drain_select_reg;
    end else if (reg_addr == gpio_pkg::OFS_P0_DATA) begin
      rdata_next = p0_view;
    end else if (reg_addr == gpio_pkg::OFS_P1_DATA) begin
      rdata_next = {6'h00, p1_view};
    end else if (reg_addr == gpio_pkg::OFS_P2_DATA) begin
      rdata_next = p2_view;
    end else if (reg_addr == gpio_pkg::OFS_P3_DATA) begin
      rdata_next = p3_view;
    end else if (reg_addr == gpio_pkg::OFS_IRQ_PENDING) begin
      rdata_next = ext_irq_pending_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // read data held until the next read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule : gpio_ports

// >>> bench/gpio_ports_sva.sv
// checker for the gpio block: reset state, register reads, port 3 irq.
// assumes it is bound onto gpio_ports and sees its ports only.
`timescale 1ns/1ps
module gpio_ports_sva (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] port0_oe,
  input wire logic [1:0] port1_oe,
  input wire logic [7:0] port2_oe,
  input wire logic [7:0] port2_pullup,
  input wire logic [7:0] port3_oe,
  input wire logic [7:0] port3_pullup,
  input wire logic [7:0] port3_in,
  // irq
  input wire logic ext_irq_n
);
  default clocking cb @(posedge clock); endclocking
  logic clr_wr;
  logic pend_rd;
  assign clr_wr = reg_wr && reg_addr == gpio_pkg::OFS_IRQ_PENDING;
  // a write in the same cycle could clear bits, so reads alone only
  assign pend_rd = reg_rd && !reg_wr
    && reg_addr == gpio_pkg::OFS_IRQ_PENDING;

  a_reset_irq_idle: assert property (sys_rst |=> ext_irq_n)
    else $error("irq request active after reset");
  a_reset_all_input: assert property (sys_rst |=>
    {port0_oe, port1_oe, port2_oe, port3_oe} == 26'h0)
    else $error("pin driven after reset");
  a_p1_mode_narrow: assert property (disable iff (sys_rst)
    reg_rd && reg_addr == gpio_pkg::OFS_P1_MODE |=> reg_rdata[7:4] == 4'h0)
    else $error("port 1 mode upper bits not zero");
  a_p1_data_narrow: assert property (disable iff (sys_rst)
    reg_rd && reg_addr == gpio_pkg::OFS_P1_DATA |=> reg_rdata[7:2] == 6'h00)
    else $error("port 1 data upper bits not zero");
  a_unmapped_zero: assert property (disable iff (sys_rst)
    reg_rd && reg_addr == 8'hE6 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_rise_clear: assert property (disable iff (sys_rst)
    $rose(ext_irq_n) |-> $past(clr_wr))
    else $error("irq released without pending write");
  a_irq_fall_edge: assert property (disable iff (sys_rst)
    $fell(ext_irq_n) |-> $past(port3_in) != $past(port3_in, 2))
    else $error("irq raised without pin edge");
  a_pending_irq_low: assert property (disable iff (sys_rst)
    pend_rd ##1 reg_rdata != 8'h00 |-> !ext_irq_n)
    else $error("pending bit set but irq idle");
  a_p2_pull_input: assert property (disable iff (sys_rst)
    (port2_pullup & port2_oe) == 8'h00)
    else $error("port 2 pull-up on driven pin");
  a_p3_pull_input: assert property (disable iff (sys_rst)
    (port3_pullup & port3_oe) == 8'h00)
    else $error("port 3 pull-up on driven pin");

  c_pend_read: cover property (pend_rd ##1 reg_rdata != 8'h00);
  c_irq_clear: cover property ($rose(ext_irq_n));
  c_open_drain: cover property (port3_oe == 8'hFA);
endmodule : gpio_ports_sva

bind gpio_ports gpio_ports_sva chk_u (.clock, .sys_rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .port0_oe, .port1_oe, .port2_oe,
  .port2_pullup, .port3_oe, .port3_pullup, .port3_in, .ext_irq_n);

// >>> bench/board_pins.sv
// board side of one port: bench drivers, pull-ups, released lines.
// assumes block outputs are registered; one instance per port.
`timescale 1ns/1ps
module board_pins #(
  parameter int W = 8
) (
  // clock
  input wire logic clock,
  // block side
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe,
  input wire logic [W-1:0] pull_on,
  // bench drivers
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // resolved level
  output logic [W-1:0] level
);
  logic [W-1:0] float_reg = '0;
  // a floating line never keeps its last value
  always_ff @(posedge clock) begin
    float_reg <= ~float_reg;
  end
  // released open-drain lines fall to bench or pull-up
  assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
    | (~drv_oe & ~ext_en & (pull_on | float_reg));
endmodule : board_pins

// >>> bench/tb.sv
// self-checking bench for gpio_ports: registers, pin modes, port 3 irq.
// assumes board_pins on every port; bench drives all pins by default.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ext_irq_n;
  logic [7:0] port0_in, port0_out, port0_oe, port0_pullup, port0_analog_sel;
  logic [1:0] port1_in, port1_out, port1_oe, port1_pullup, port1_analog_sel;
  logic [7:0] port2_in, port2_out, port2_oe, port2_pullup;
  logic [7:0] port3_in, port3_out, port3_oe, port3_pullup;
  logic [7:0] port0_alt_out = 8'h00, port2_alt_out = 8'h00;
  logic [7:0] ext0_val = 8'h00, ext2_val = 8'h00, ext3_val = 8'h00;
  logic [1:0] ext1_val = 2'h0;
  logic [7:0] ext0_en = 8'hFF, ext2_en = 8'hFF, ext3_en = 8'hFF;
  logic [1:0] ext1_en = 2'h3;
  int mismatches = 0;
  int total_checks = 0;

  always #25 clock = ~clock;

  gpio_ports dut_u (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .port0_in, .port0_out, .port0_oe, .port0_pullup,
    .port0_analog_sel, .port0_alt_out, .port1_in, .port1_out, .port1_oe,
    .port1_pullup, .port1_analog_sel, .port2_in, .port2_out, .port2_oe,
    .port2_pullup, .port2_alt_out, .port3_in, .port3_out, .port3_oe,
    .port3_pullup, .ext_irq_n);
  board_pins #(.W(8)) brd0_u (.clock, .drv_out(port0_out), .drv_oe(port0_oe),
    .pull_on(port0_pullup), .ext_val(ext0_val), .ext_en(ext0_en),
    .level(port0_in));
  board_pins #(.W(2)) brd1_u (.clock, .drv_out(port1_out), .drv_oe(port1_oe),
    .pull_on(port1_pullup), .ext_val(ext1_val), .ext_en(ext1_en),
    .level(port1_in));
  board_pins #(.W(8)) brd2_u (.clock, .drv_out(port2_out), .drv_oe(port2_oe),
    .pull_on(port2_pullup), .ext_val(ext2_val), .ext_en(ext2_en),
    .level(port2_in));
  board_pins #(.W(8)) brd3_u (.clock, .drv_out(port3_out), .drv_oe(port3_oe),
    .pull_on(port3_pullup), .ext_val(ext3_val), .ext_en(ext3_en),
    .level(port3_in));

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // strobe idles one cycle so no signal is set twice in a time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    rv = reg_rdata;
    step(1);
  endtask : rd

  task automatic t_reset;
    for (int a = 8'hE0; a <= 8'hF1; a++) begin
      rd(8'(a));
      `CHK(rv, 8'h00)
    end
    `CHK(ext_irq_n, 1'b1)
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] ofs [12] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
      8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEB, 8'hEC};
    logic [7:0] pat, exp;
    for (int k = 0; k < 2; k++) begin
      pat = k ? 8'h5A : 8'hA5;
      foreach (ofs[i]) begin
        wr(ofs[i], pat);
        rd(ofs[i]);
        exp = ofs[i] == 8'hE3 ? (pat & 8'h0F) : pat;
        exp = ofs[i] == 8'hE6 ? 8'h00 : exp;
        `CHK(rv, exp)
      end
    end
    foreach (ofs[i]) wr(ofs[i], 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_port0;
    wr(8'hE0, 8'h55);
    wr(8'hE1, 8'h54);
    wr(8'hED, 8'h3D);
    `CHK(port0_oe, 8'hFE)
    `CHK(port0_out & port0_oe, 8'h3C)
    rd(8'hED);
    `CHK(rv, 8'h3C)
    ext0_val = 8'hC3;
    wr(8'hE0, 8'h00);
    wr(8'hE1, 8'h00);
    wr(8'hE2, 8'hFF);
    rd(8'hED);
    `CHK(rv, 8'hC3)
    `CHK(port0_pullup, 8'hFF)
    port0_alt_out = 8'h96;
    wr(8'hE0, 8'hAA);
    wr(8'hE1, 8'hAA);
    `CHK(port0_out, 8'h96)
    `CHK(port0_pullup, 8'h00)
    wr(8'hE0, 8'hFF);
    wr(8'hE1, 8'hFF);
    `CHK(port0_analog_sel, 8'hFF)
    `CHK(port0_oe, 8'h00)
    for (int a = 8'hE0; a <= 8'hE2; a++) wr(8'(a), 8'h00);
    $display("test port 0 done");
  endtask : t_port0

  task automatic t_port1;
    wr(8'hE3, 8'h05);
    `CHK(port1_pullup, 2'h3)
    // released lines: two reads an odd cycle count apart beat a lucky float
    ext1_en = 2'h0;
    rd(8'hEE);
    `CHK(rv, 8'h03)
    step(1);
    rd(8'hEE);
    `CHK(rv, 8'h03)
    ext1_en = 2'h3;
    wr(8'hEE, 8'hFE);
    wr(8'hE3, 8'h0A);
    `CHK(port1_oe, 2'h3)
    `CHK(port1_out, 2'h2)
    rd(8'hEE);
    `CHK(rv, 8'h02)
    wr(8'hE3, 8'h0F);
    `CHK(port1_analog_sel, 2'h3)
    wr(8'hE3, 8'h00);
    $display("test port 1 done");
  endtask : t_port1

  task automatic t_port2;
    wr(8'hE4, 8'hAA);
    wr(8'hE5, 8'hAA);
    wr(8'hEF, 8'h0F);
    `CHK(port2_oe, 8'hF0)
    `CHK(port2_out & port2_oe, 8'h00)
    wr(8'hE4, 8'h55);
    wr(8'hE5, 8'h55);
    `CHK(port2_oe, 8'hFF)
    `CHK(port2_out, 8'h0F)
    port2_alt_out = 8'h5A;
    wr(8'hE4, 8'hFF);
    wr(8'hE5, 8'hFF);
    `CHK(port2_out, 8'h5A)
    wr(8'hE4, 8'h00);
    wr(8'hE5, 8'h00);
    wr(8'hE7, 8'h81);
    `CHK(port2_pullup, 8'h81)
    ext2_en = 8'h7E;
    rd(8'hEF);
    `CHK(rv, 8'h81)
    step(1);
    rd(8'hEF);
    `CHK(rv, 8'h81)
    ext2_en = 8'hFF;
    wr(8'hE7, 8'h00);
    $display("test port 2 done");
  endtask : t_port2

  task automatic t_port3;
    wr(8'hE8, 8'hFF);
    wr(8'hE9, 8'hFF);
    wr(8'hEC, 8'h0F);
    wr(8'hF0, 8'h35);
    `CHK(port3_oe, 8'hFA)
    `CHK(port3_out & port3_oe, 8'h30)
    for (int a = 8'hE8; a <= 8'hEC; a++) wr(8'(a), 8'h00);
    wr(8'hEB, 8'h3C);
    `CHK(port3_pullup, 8'h3C)
    ext3_en = 8'hC3;
    rd(8'hF0);
    `CHK(rv, 8'h3C)
    step(1);
    rd(8'hF0);
    `CHK(rv, 8'h3C)
    ext3_en = 8'hFF;
    wr(8'hEB, 8'h00);
    $display("test port 3 output done");
  endtask : t_port3

  task automatic pin3(input logic [7:0] v, input logic [7:0] exp);
    ext3_val = v;
    step(2);
    rd(8'hF1);
    `CHK(rv, exp)
  endtask : pin3

  task automatic t_irq;
    ext3_val = 8'hFF;
    step(2);
    wr(8'hEA, 8'hFF);
    pin3(8'hFE, 8'h01);
    `CHK(ext_irq_n, 1'b0)
    pin3(8'hFF, 8'h01);
    wr(8'hF1, 8'hFE);
    `CHK(ext_irq_n, 1'b1)
    wr(8'hE8, 8'h55);
    wr(8'hE9, 8'h55);
    pin3(8'h7F, 8'h00);
    pin3(8'hFF, 8'h80);
    wr(8'hF1, 8'h00);
    wr(8'hE8, 8'hAA);
    wr(8'hE9, 8'hAA);
    pin3(8'hFD, 8'h02);
    wr(8'hF1, 8'h00);
    pin3(8'hFF, 8'h02);
    wr(8'hF1, 8'h00);
    wr(8'hEA, 8'hFE);
    pin3(8'hFE, 8'h00);
    wr(8'hEA, 8'hFF);
    step(2);
    `CHK(ext_irq_n, 1'b1)
    for (int a = 8'hE8; a <= 8'hEA; a++) wr(8'(a), 8'h00);
    $display("test port 3 irq done");
  endtask : t_irq

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // hang guard: bounded run length
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_port0();
    t_port1();
    t_port2();
    t_port3();
    t_irq();
    give_verdict();
  end
endmodule : tb
